// ===== dv/rds_block_sync_sva.sv
// port checker for the block sync receiver
`timescale 1ns/10ps
module rds_block_sync_sva
    import rds_sync_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic link_clk,
    input wire logic link_data,
    input wire logic group_ready,
    input wire logic group_valid,
    input wire group_words_s group_words,
    input wire group_info_s group_info,
    input wire logic in_sync,
    input wire logic buffer_overflow
);
    logic [3:0] quiet_q;
    logic [3:0] quiet_d;
    logic link_q;
    logic link_d;

    // cycles since the link clock last moved, saturating
    always_comb begin
        link_d = link_clk;
        quiet_d = (quiet_q == 4'hf) ? quiet_q : quiet_q + 4'h1;
        if (sys_rst || link_clk != link_q) begin
            quiet_d = 4'h0;
        end
    end

    always_ff @(posedge clock) begin
        quiet_q <= quiet_d;
        link_q <= link_d;
    end

    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence s_link_quiet;
        quiet_q >= 4'ha;
    endsequence

    a_valid_needs_ready: assert property (group_valid |-> $past(group_ready))
        else $error("group delivered without ready");
    a_words_held: assert property (!group_valid |-> $stable(group_words))
        else $error("group words moved without strobe");
    a_info_held: assert property (!group_valid |-> $stable(group_info))
        else $error("group info moved without strobe");
    a_type_field: assert property (group_valid |->
        group_info.group_type == group_words.block_b[15:12])
        else $error("group type field mismatch");
    a_flag_fields: assert property (group_valid |->
        group_info.traffic_programme_flag == group_words.block_b[10] &&
        group_info.programme_category_code == group_words.block_b[9:5])
        else $error("flag or category field mismatch");
    a_overflow_sticky: assert property (buffer_overflow |=> buffer_overflow)
        else $error("overflow flag cleared without reset");
    a_sync_on_bits: assert property (s_link_quiet |-> $stable(in_sync))
        else $error("sync state changed with no link bit");
    a_overflow_needs_stall: assert property ($rose(buffer_overflow) |->
        $past(group_ready) == 1'b0)
        else $error("overflow raised while consumer ready");
endmodule : rds_block_sync_sva

bind rds_block_sync rds_block_sync_sva chk (.clock, .sys_rst, .link_clk, .link_data,
    .group_ready, .group_valid, .group_words, .group_info, .in_sync, .buffer_overflow);

// ===== dv/rds_demod_model.sv
// behavioural demodulator driving the link bit clock and data
`timescale 1ns/10ps
module rds_demod_model (
    output logic link_clk,
    output logic link_data
);
    initial begin
        link_clk = 1'b0;
        link_data = 1'b1;
    end

    // one bit every 800 ns; clock stands low between frames
    task automatic send_block(input logic [25:0] w);
        for (int i = 25; i >= 0; i--) begin
            // off the system clock edge, and never twice in one step
            #13;
            link_data = w[i];
            #230;
            link_clk = 1'b1;
            #400;
            link_clk = 1'b0;
            #157;
        end
        link_data = ~w[0];
    endtask : send_block
endmodule : rds_demod_model

// ===== dv/testbench.sv
// self-checking bench for the block sync receiver
`timescale 1ns/10ps
module testbench;
    import rds_sync_pkg::*;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic group_ready = 1'b1;
    logic link_clk;
    logic link_data;
    logic group_valid;
    logic in_sync;
    logic buffer_overflow;
    group_words_s group_words;
    group_info_s group_info;
    group_words_s got_q[$];
    group_info_s info_q[$];
    int fail_count = 0;
    int n_checks = 0;

    always #50 clock = ~clock;

    rds_demod_model demod (.link_clk, .link_data);
    rds_block_sync dut (.clock, .sys_rst, .link_clk, .link_data, .group_ready,
        .group_valid, .group_words, .group_info, .in_sync, .buffer_overflow);

    always @(posedge clock) begin
        if (group_valid === 1'b1) begin
            got_q.push_back(group_words);
            info_q.push_back(group_info);
        end
    end

    // block with check bits chosen so its syndrome equals the offset
    function automatic logic [25:0] blk(input logic [15:0] info, input logic [9:0] off);
        logic [25:0] w;
        logic [9:0] s;
        for (int c = 0; c < 1024; c++) begin
            w = {info, c[9:0]};
            s = 10'h0_00;
            for (int i = 0; i < 26; i++) begin
                if (w[25 - i]) s ^= CHECK_ROW[i];
            end
            if (s == off) return w;
        end
        return 26'h0;
    endfunction : blk

    task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    task automatic send_group(input group_words_s g, input logic vb);
        demod.send_block(blk(g.station_identifier, SYN_A));
        demod.send_block(blk(g.block_b, SYN_B));
        demod.send_block(blk(g.block_c, vb ? SYN_CP : SYN_C));
        demod.send_block(blk(g.block_d, SYN_D));
        repeat (20) @(posedge clock);
    endtask : send_group

    task automatic check_next(input group_words_s g, input logic vb);
        group_info_s e;
        e = {g.block_b[15:12], vb, g.block_b[10], g.block_b[9:5]};
        cmp("group present", 64'h1, 64'(got_q.size() > 0));
        if (got_q.size() > 0) begin
            cmp("group words", g, got_q.pop_front());
            cmp("group info", {53'h0, e}, {53'h0, info_q.pop_front()});
        end
    endtask : check_next

    task automatic t_acquire();
        group_words_s g = 64'h5A3C_2B65_0123_4567;
        demod.send_block(blk(16'hC0DE, SYN_B));
        demod.send_block(blk(g.station_identifier, SYN_A));
        demod.send_block(blk(g.block_b, SYN_B));
        demod.send_block(blk(g.block_c, SYN_C));
        repeat (20) @(posedge clock);
        cmp("early group", 64'h0, 64'(got_q.size()));
        demod.send_block(blk(g.block_d, SYN_D));
        repeat (20) @(posedge clock);
        check_next(g, 1'b0);
    endtask : t_acquire

    task automatic t_version_b();
        group_words_s g = 64'h7E01_1AB4_7E01_9C3D;
        send_group(g, 1'b1);
        check_next(g, 1'b1);
        cmp("in sync", 64'h1, {63'h0, in_sync});
    endtask : t_version_b

    task automatic t_lost_sync();
        group_words_s g = 64'h3141_F3E0_2718_AAAA;
        demod.send_block(blk(g.station_identifier, SYN_A));
        demod.send_block(blk(g.block_b, SYN_B));
        demod.send_block(blk(g.block_c, SYN_D));
        repeat (20) @(posedge clock);
        cmp("in sync", 64'h0, {63'h0, in_sync});
        cmp("broken group", 64'h0, 64'(got_q.size()));
        send_group(g, 1'b0);
        check_next(g, 1'b0);
    endtask : t_lost_sync

    task automatic t_stall();
        group_words_s g[3] = '{64'h1111_0800_2222_3333, 64'h4444_F41F_5555_6666,
            64'h7777_2A40_8888_9999};
        @(posedge clock) group_ready <= 1'b0;
        for (int k = 0; k < 3; k++) send_group(g[k], 1'b0);
        cmp("stalled groups", 64'h0, 64'(got_q.size()));
        cmp("overflow", 64'h1, {63'h0, buffer_overflow});
        @(posedge clock) group_ready <= 1'b1;
        repeat (20) @(posedge clock);
        check_next(g[0], 1'b0);
        check_next(g[1], 1'b0);
        cmp("extra groups", 64'h0, 64'(got_q.size()));
    endtask : t_stall

    task automatic t_reset();
        group_words_s g = 64'h2468_5C20_1357_BEEF;
        @(posedge clock) sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        cmp("overflow after reset", 64'h0, {63'h0, buffer_overflow});
        cmp("sync after reset", 64'h0, {63'h0, in_sync});
        cmp("words after reset", 64'h0, group_words);
        send_group(g, 1'b0);
        check_next(g, 1'b0);
    endtask : t_reset

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        t_acquire();
        t_version_b();
        t_lost_sync();
        t_stall();
        t_reset();
        print_verdict();
    end

    initial begin
        #2ms;
        fail_count++;
        print_verdict();
    end
endmodule : testbench

// ===== inc/rds_sync_pkg.sv
// shared constants and carrier types for the block sync receiver
package rds_sync_pkg;
    localparam int BLOCK_BITS = 26;
    localparam int INFO_BITS = 16;
    localparam int CHECK_BITS = 10;
    localparam int BLOCKS_PER_GROUP = 4;
    localparam logic [9:0] SYN_A = 10'h3_D8;
    localparam logic [9:0] SYN_B = 10'h3_D4;
    localparam logic [9:0] SYN_C = 10'h2_5C;
    localparam logic [9:0] SYN_CP = 10'h3_CC;
    localparam logic [9:0] SYN_D = 10'h1_58;
    // parity-check rows, index 0 is the oldest of the 26 bits
    localparam logic [9:0] CHECK_ROW [0:25] = '{
        10'h2_00, 10'h1_00, 10'h0_80, 10'h0_40, 10'h0_20, 10'h0_10, 10'h0_08,
        10'h0_04, 10'h0_02, 10'h0_01, 10'h2_DC, 10'h1_6E, 10'h0_B7, 10'h2_87,
        10'h3_9F, 10'h3_13, 10'h3_55, 10'h3_76, 10'h1_BB, 10'h2_01, 10'h3_DC,
        10'h1_EE, 10'h0_F7, 10'h2_A7, 10'h3_8F, 10'h3_1B};
    localparam logic [4:0] BIT_COUNT_RESET = 5'h0_0;
    localparam logic [4:0] BIT_COUNT_LAST = 5'h1_9;
    localparam real BIT_RATE_HZ = 1187.5;
    localparam real CLOCK_HZ = 10.0e6;
    localparam int CYCLES_PER_BIT = int'(CLOCK_HZ / BIT_RATE_HZ);

    typedef struct packed {
        logic [15:0] station_identifier;
        logic [15:0] block_b;
        logic [15:0] block_c;
        logic [15:0] block_d;
    } group_words_s;

    typedef struct packed {
        logic [3:0] group_type;
        logic version_b;
        logic traffic_programme_flag;
        logic [4:0] programme_category_code;
    } group_info_s;
endpackage : rds_sync_pkg

// ===== verilog/rds_bit_sampler.sv
// double-flop synchroniser and rising-edge sampler for the demodulator link
`timescale 1ns/10ps
module rds_bit_sampler
    import rds_sync_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic link_clk,
    input wire logic link_data,
    output logic bit_strobe,
    output logic bit_value
);
    logic [1:0] clk_sync_q, clk_sync_d;
    logic [1:0] dat_sync_q, dat_sync_d;
    logic clk_prev_q, clk_prev_d;
    logic strobe_q, strobe_d;
    logic value_q, value_d;

    always_comb begin
        clk_sync_d = {clk_sync_q[0], link_clk};
        dat_sync_d = {dat_sync_q[0], link_data};
        clk_prev_d = clk_sync_q[1];
        strobe_d = clk_sync_q[1] & ~clk_prev_q;
        value_d = strobe_d ? dat_sync_q[1] : value_q;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            clk_sync_q <= 2'h0;
            dat_sync_q <= 2'h0;
            clk_prev_q <= 1'b0;
            strobe_q <= 1'b0;
            value_q <= 1'b0;
        end else begin
            clk_sync_q <= clk_sync_d;
            dat_sync_q <= dat_sync_d;
            clk_prev_q <= clk_prev_d;
            strobe_q <= strobe_d;
            value_q <= value_d;
        end
    end

    assign bit_strobe = strobe_q;
    assign bit_value = value_q;
endmodule : rds_bit_sampler

// ===== verilog/rds_block_sync.sv
// block and group synchroniser for a serial radio data stream
`timescale 1ns/10ps
module rds_block_sync
    import rds_sync_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic link_clk,
    input wire logic link_data,
    input wire logic group_ready,
    output logic group_valid,
    output group_words_s group_words,
    output group_info_s group_info,
    output logic in_sync,
    output logic buffer_overflow
);
    typedef enum logic [4:0] {
        ST_SEARCH = 5'b0_0001,
        ST_EXP_B = 5'b0_0010,
        ST_EXP_C = 5'b0_0100,
        ST_EXP_D = 5'b0_1000,
        ST_EXP_A = 5'b1_0000
    } sync_state_e;

    localparam int PACKED_W = $bits(group_words_s) + $bits(group_info_s);

    logic bit_strobe;
    logic bit_value;
    logic [BLOCK_BITS-1:0] shift_q, shift_d;
    logic [9:0] syndrome;
    sync_state_e state_q, state_d;
    logic [4:0] count_q, count_d;
    group_words_s tmp_q, tmp_d;
    logic version_q, version_d;
    logic push_valid;
    logic push_ready;
    logic [PACKED_W-1:0] push_data;
    logic pop_valid;
    logic [PACKED_W-1:0] pop_data;
    logic gv_q, gv_d;
    group_words_s words_q, words_d;
    group_info_s info_q, info_d;
    logic sync_q, sync_d;
    logic ovf_q, ovf_d;
    logic [15:0] info_word;
    logic boundary;

    rds_bit_sampler u_sampler (
        .clock(clock),
        .sys_rst(sys_rst),
        .link_clk(link_clk),
        .link_data(link_data),
        .bit_strobe(bit_strobe),
        .bit_value(bit_value)
    );

    // syndrome of the window including the bit just arriving
    always_comb begin
        shift_d = bit_strobe ? {shift_q[BLOCK_BITS-2:0], bit_value} : shift_q;
        syndrome = 10'h0_00;
        for (int i = 0; i < BLOCK_BITS; i++) begin
            if (shift_d[BLOCK_BITS-1-i]) begin
                syndrome = syndrome ^ CHECK_ROW[i];
            end
        end
    end

    // info word is the 16 oldest bits of the window
    assign info_word = shift_d[BLOCK_BITS-1:CHECK_BITS];
    assign boundary = bit_strobe && (count_q == BIT_COUNT_LAST);

    always_comb begin
        state_d = state_q;
        count_d = count_q;
        tmp_d = tmp_q;
        version_d = version_q;
        push_valid = 1'b0;
        if (bit_strobe) begin
            count_d = (count_q == BIT_COUNT_LAST) ? BIT_COUNT_RESET : 5'(count_q + 5'h0_1);
        end
        unique case (state_q)
            ST_SEARCH: begin
                if (bit_strobe && syndrome == SYN_A) begin
                    tmp_d.station_identifier = info_word;
                    state_d = ST_EXP_B;
                    count_d = BIT_COUNT_RESET;
                end
            end
            ST_EXP_B: begin
                if (boundary) begin
                    if (syndrome == SYN_B) begin
                        tmp_d.block_b = info_word;
                        state_d = ST_EXP_C;
                    end else begin
                        state_d = ST_SEARCH;
                    end
                end
            end
            ST_EXP_C: begin
                if (boundary) begin
                    if (syndrome == SYN_C || syndrome == SYN_CP) begin
                        tmp_d.block_c = info_word;
                        version_d = (syndrome == SYN_CP);
                        state_d = ST_EXP_D;
                    end else begin
                        state_d = ST_SEARCH;
                    end
                end
            end
            ST_EXP_D: begin
                if (boundary) begin
                    if (syndrome == SYN_D) begin
                        tmp_d.block_d = info_word;
                        push_valid = 1'b1;
                        state_d = ST_EXP_A;
                    end else begin
                        state_d = ST_SEARCH;
                    end
                end
            end
            ST_EXP_A: begin
                if (boundary) begin
                    if (syndrome == SYN_A) begin
                        tmp_d.station_identifier = info_word;
                        state_d = ST_EXP_B;
                    end else begin
                        state_d = ST_SEARCH;
                    end
                end
            end
            default: begin
                state_d = ST_SEARCH;
            end
        endcase
    end

    // group words plus decoded block-two fields and the version flag from the block-three offset enter the buffer
    always_comb begin
        group_info_s inf;
        inf = '0;
        inf.group_type = tmp_d.block_b[15:12];
        inf.version_b = version_d;
        inf.traffic_programme_flag = tmp_d.block_b[10];
        inf.programme_category_code = tmp_d.block_b[9:5];
        push_data = {tmp_d, inf};
    end

    rds_skid_buffer #(
        .WIDTH(PACKED_W)
    ) u_buffer (
        .clock(clock),
        .sys_rst(sys_rst),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(push_data),
        .out_valid(pop_valid),
        .out_ready(group_ready),
        .out_data(pop_data)
    );

    always_comb begin
        gv_d = pop_valid & group_ready;
        words_d = words_q;
        info_d = info_q;
        if (pop_valid && group_ready) begin
            {words_d, info_d} = pop_data;
        end
        sync_d = (state_d != ST_SEARCH);
        ovf_d = ovf_q | (push_valid & ~push_ready);
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            shift_q <= '0;
            state_q <= ST_SEARCH;
            count_q <= BIT_COUNT_RESET;
            tmp_q <= '0;
            version_q <= 1'b0;
            gv_q <= 1'b0;
            words_q <= '0;
            info_q <= '0;
            sync_q <= 1'b0;
            ovf_q <= 1'b0;
        end else begin
            shift_q <= shift_d;
            state_q <= state_d;
            count_q <= count_d;
            tmp_q <= tmp_d;
            version_q <= version_d;
            gv_q <= gv_d;
            words_q <= words_d;
            info_q <= info_d;
            sync_q <= sync_d;
            ovf_q <= ovf_d;
        end
    end

    assign group_valid = gv_q;
    assign group_words = words_q;
    assign group_info = info_q;
    assign in_sync = sync_q;
    assign buffer_overflow = ovf_q;
endmodule : rds_block_sync

// ===== verilog/rds_skid_buffer.sv
// two-entry buffer with valid/ready on both sides
`timescale 1ns/10ps
module rds_skid_buffer #(
    parameter int WIDTH = 75
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem_q [0:1];
    logic [WIDTH-1:0] mem_d [0:1];
    logic rd_q, rd_d, wr_q, wr_d;
    logic [1:0] cnt_q, cnt_d;
    logic push, pop;

    always_comb begin
        push = in_valid & (cnt_q != 2'h2);
        pop = out_ready & (cnt_q != 2'h0);
        mem_d = mem_q;
        if (push) begin
            mem_d[wr_q] = in_data;
        end
        wr_d = wr_q ^ push;
        rd_d = rd_q ^ pop;
        cnt_d = 2'(cnt_q + {1'b0, push} - {1'b0, pop});
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mem_q <= '{default: '0};
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            mem_q <= mem_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            cnt_q <= cnt_d;
        end
    end

    assign in_ready = cnt_q != 2'h2;
    assign out_valid = cnt_q != 2'h0;
    assign out_data = mem_q[rd_q];
endmodule : rds_skid_buffer
